// [logic/b2s_bus_master.sv]
`timescale 1ns/1ps
`include "b2s_params.svh"

module b2s_bus_master (
  b2s_if.ctl lnk,
  input logic mclk,
  input logic rst,
  input logic lock_bypass_req_n,
  input logic req_valid,
  input logic req_write,
  input b2s_pkg::b2s_addr_t req_addr,
  input b2s_pkg::b2s_data_t req_wdata0,
  input b2s_pkg::b2s_data_t req_wdata1,
  input b2s_pkg::b2s_mask_t req_mask0_n,
  input b2s_pkg::b2s_mask_t req_mask1_n,
  output logic req_ready,
  output logic rd_valid,
  output b2s_pkg::b2s_data_t rd_data0,
  output b2s_pkg::b2s_data_t rd_data1
);

  b2s_pkg::b2s_mst_state_t state_d;
  b2s_pkg::b2s_mst_state_t state_q;
  logic [1:0] ph_d;
  logic [1:0] ph_q;
  logic k_d;
  logic k_q;
  logic [3:0] rcnt_d;
  logic [3:0] rcnt_q;
  logic lrst_d;
  logic lrst_q;
  logic bypn_d;
  logic bypn_q;
  logic ld_n_d;
  logic ld_n_q;
  logic rnw_d;
  logic rnw_q;
  logic ready_d;
  logic ready_q;
  b2s_pkg::b2s_addr_t a_d;
  b2s_pkg::b2s_addr_t a_q;
  b2s_pkg::b2s_data_t d_d;
  b2s_pkg::b2s_data_t d_q;
  b2s_pkg::b2s_data_t w1_d;
  b2s_pkg::b2s_data_t w1_q;
  b2s_pkg::b2s_mask_t m_d;
  b2s_pkg::b2s_mask_t m_q;
  b2s_pkg::b2s_mask_t m1_d;
  b2s_pkg::b2s_mask_t m1_q;
  logic pre_rise;
  logic pre_fall;

  // Link clock is mclk divided by four and runs without pause outside reset.
  // Outputs change a quarter period before the device edge that samples them.
  always_comb begin
    ph_d = ph_q + 2'h1;
    k_d = !ph_d[1];
    pre_rise = (ph_q == `B2S_PH_PRE_RISE);
    pre_fall = (ph_q == `B2S_PH_PRE_FALL);
    rcnt_d = (pre_rise && rcnt_q != 4'h0) ? rcnt_q - 4'h1 : rcnt_q;
    // Link reset drops only ahead of a device rising edge, never on it, and requests wait a few
    // more link cycles so the device's reset synchroniser has let go before the first command.
    lrst_d = pre_rise ? (rcnt_d > `B2S_LINK_SYNC_CYC) : lrst_q;
    bypn_d = bypn_q;
    state_d = state_q;
    ld_n_d = ld_n_q;
    rnw_d = rnw_q;
    a_d = a_q;
    d_d = d_q;
    m_d = m_q;
    w1_d = w1_q;
    m1_d = m1_q;
    unique case (state_q)
      b2s_pkg::B2S_IDLE: begin
        if (pre_rise && req_valid && ready_q) begin
          ld_n_d = 1'b0;
          rnw_d = !req_write;
          a_d = req_addr;
          d_d = req_wdata0;
          m_d = req_mask0_n;
          w1_d = req_wdata1;
          m1_d = req_mask1_n;
          state_d = b2s_pkg::B2S_CMD;
        end
      end
      b2s_pkg::B2S_CMD: begin
        if (pre_rise) begin
          ld_n_d = 1'b1;
          state_d = rnw_q ? b2s_pkg::B2S_GAP : b2s_pkg::B2S_WB;
        end
      end
      b2s_pkg::B2S_GAP: begin
        if (pre_fall) begin
          state_d = b2s_pkg::B2S_IDLE;
        end
      end
      b2s_pkg::B2S_WB: begin
        if (pre_fall) begin
          d_d = w1_q;
          m_d = m1_q;
          state_d = b2s_pkg::B2S_IDLE;
        end
      end
    endcase
    ready_d = (state_d == b2s_pkg::B2S_IDLE) && (ph_d == `B2S_PH_PRE_RISE) && (rcnt_d == 4'h0);
    if (rst) begin
      ph_d = 2'h0;
      k_d = 1'b0;
      rcnt_d = `B2S_LINK_RST_CYC;
      lrst_d = 1'b1;
      bypn_d = lock_bypass_req_n;
      state_d = b2s_pkg::B2S_IDLE;
      ld_n_d = 1'b1;
      rnw_d = 1'b1;
      a_d = '0;
      d_d = '0;
      m_d = '1;
      w1_d = '0;
      m1_d = '1;
      ready_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    ph_q <= ph_d;
    k_q <= k_d;
    rcnt_q <= rcnt_d;
    lrst_q <= lrst_d;
    bypn_q <= bypn_d;
    state_q <= state_d;
    ld_n_q <= ld_n_d;
    rnw_q <= rnw_d;
    a_q <= a_d;
    d_q <= d_d;
    m_q <= m_d;
    w1_q <= w1_d;
    m1_q <= m1_d;
    ready_q <= ready_d;
  end

  assign lnk.k = k_q;
  assign lnk.link_rst = lrst_q;
  assign lnk.lock_bypass_n = bypn_q;
  assign lnk.new_address_select_n = ld_n_q;
  assign lnk.read_not_write = rnw_q;
  assign lnk.a = a_q;
  assign lnk.d = d_q;
  assign lnk.byte_lane_mask0_n = m_q[0];
  assign lnk.byte_lane_mask1_n = m_q[1];
  assign lnk.byte_lane_mask2_n = m_q[2];
  assign lnk.byte_lane_mask3_n = m_q[3];
  assign req_ready = ready_q;

  // Read return passes two flops, then is sampled mid-beat on the phase that suits the latency mode.
  b2s_pkg::b2s_data_t q_s1_q;
  b2s_pkg::b2s_data_t q_s2_q;
  logic oe_s1_q;
  logic oe_s2_q;
  logic samp;
  logic bt_d;
  logic bt_q;
  logic rdv_d;
  logic rdv_q;
  b2s_pkg::b2s_data_t rd0_d;
  b2s_pkg::b2s_data_t rd0_q;
  b2s_pkg::b2s_data_t rd1_d;
  b2s_pkg::b2s_data_t rd1_q;

  always_ff @(posedge mclk) begin
    q_s1_q <= lnk.q;
    q_s2_q <= q_s1_q;
    oe_s1_q <= lnk.q_oe;
    oe_s2_q <= oe_s1_q;
  end

  always_comb begin
    samp = bypn_q ? (ph_q == `B2S_PH_SAMPLE_NORM) : (ph_q == `B2S_PH_SAMPLE_BYP);
    bt_d = bt_q;
    rd0_d = rd0_q;
    rd1_d = rd1_q;
    rdv_d = 1'b0;
    if (samp && oe_s2_q) begin
      if (!bt_q) begin
        rd0_d = q_s2_q;
        bt_d = 1'b1;
      end else begin
        rd1_d = q_s2_q;
        bt_d = 1'b0;
        rdv_d = 1'b1;
      end
    end
    if (rst) begin
      bt_d = 1'b0;
      rd0_d = '0;
      rd1_d = '0;
      rdv_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    bt_q <= bt_d;
    rd0_q <= rd0_d;
    rd1_q <= rd1_d;
    rdv_q <= rdv_d;
  end

  assign rd_valid = rdv_q;
  assign rd_data0 = rd0_q;
  assign rd_data1 = rd1_q;

endmodule // b2s_bus_master

// [logic/b2s_params.svh]
`ifndef B2S_PARAMS_SVH
`define B2S_PARAMS_SVH

`define B2S_ADDR_W 19
`define B2S_DATA_W 36
`define B2S_LANES 4
`define B2S_LANE_W 9
`define B2S_MEM_IDX_W 10
`define B2S_BURST_START 2'h0
`define B2S_BEAT0 2'h0
`define B2S_BEAT1 2'h1
`define B2S_LINK_RST_CYC 4'h8
`define B2S_LINK_SYNC_CYC 4'h3
`define B2S_PH_PRE_RISE 2'h2
`define B2S_PH_PRE_FALL 2'h0
`define B2S_PH_SAMPLE_NORM 2'h3
`define B2S_PH_SAMPLE_BYP 2'h1

`endif

// [logic/b2s_pkg.sv]
`include "b2s_params.svh"

package b2s_pkg;

  typedef logic [`B2S_ADDR_W-1:0] b2s_addr_t;
  typedef logic [`B2S_DATA_W-1:0] b2s_data_t;
  typedef logic [`B2S_LANES-1:0] b2s_mask_t;

  typedef enum logic [1:0] {
    B2S_IDLE = 2'b00,
    B2S_CMD = 2'b01,
    B2S_GAP = 2'b10,
    B2S_WB = 2'b11
  } b2s_mst_state_t;

endpackage

// [logic/b2s_if.sv]
`timescale 1ns/1ps
`include "b2s_params.svh"

interface b2s_if;
  logic k;
  logic link_rst;
  logic lock_bypass_n;
  logic new_address_select_n;
  logic read_not_write;
  b2s_pkg::b2s_addr_t a;
  b2s_pkg::b2s_data_t d;
  logic byte_lane_mask0_n;
  logic byte_lane_mask1_n;
  logic byte_lane_mask2_n;
  logic byte_lane_mask3_n;
  b2s_pkg::b2s_data_t q;
  logic q_oe;

  modport mem (
    input k,
    input link_rst,
    input lock_bypass_n,
    input new_address_select_n,
    input read_not_write,
    input a,
    input d,
    input byte_lane_mask0_n,
    input byte_lane_mask1_n,
    input byte_lane_mask2_n,
    input byte_lane_mask3_n,
    output q,
    output q_oe
  );

  modport ctl (
    output k,
    output link_rst,
    output lock_bypass_n,
    output new_address_select_n,
    output read_not_write,
    output a,
    output d,
    output byte_lane_mask0_n,
    output byte_lane_mask1_n,
    output byte_lane_mask2_n,
    output byte_lane_mask3_n,
    input q,
    input q_oe
  );
endinterface

// [logic/b2s_sram_port.sv]
`timescale 1ns/1ps
`include "b2s_params.svh"

module b2s_sram_port (
  b2s_if.mem lnk,
  output logic bypass_active,
  output logic write_commit
);

  localparam int LW = `B2S_LANE_W;
  localparam int IW = `B2S_MEM_IDX_W;
  localparam int DEPTH = 1 << IW;

  // Reset and bypass strap come from the controller and are brought onto the link clock.
  logic rst_s1_q;
  logic rst_s2_q;
  logic byp_s1_q;
  logic byp_s2_q;

  always_ff @(posedge lnk.k) begin
    rst_s1_q <= lnk.link_rst;
    rst_s2_q <= rst_s1_q;
    byp_s1_q <= lnk.lock_bypass_n;
    byp_s2_q <= byp_s1_q;
  end

  // The bypass strap is caught while reset is held and frozen afterwards.
  logic byp_d;
  logic byp_q;

  always_comb begin
    byp_d = byp_q;
    if (rst_s2_q) begin
      byp_d = !byp_s2_q;
    end
  end

  always_ff @(posedge lnk.k) begin
    byp_q <= byp_d;
  end

  assign bypass_active = byp_q;

  // Command pipeline: stage 1 holds the command taken at edge t, stage 2 the one from t-1.
  logic rd1_d;
  logic rd1_q;
  logic rd2_d;
  logic rd2_q;
  logic wr1_d;
  logic wr1_q;
  logic wr2_d;
  logic wr2_q;
  logic commit_d;
  logic commit_q;
  b2s_pkg::b2s_addr_t ra1_d;
  b2s_pkg::b2s_addr_t ra1_q;
  b2s_pkg::b2s_addr_t ra2_d;
  b2s_pkg::b2s_addr_t ra2_q;

  always_comb begin
    rd1_d = 1'b0;
    wr1_d = 1'b0;
    ra1_d = ra1_q;
    if (!lnk.new_address_select_n) begin
      ra1_d = lnk.a;
      rd1_d = lnk.read_not_write;
      wr1_d = !lnk.read_not_write;
    end
    rd2_d = rd1_q;
    wr2_d = wr1_q;
    ra2_d = ra1_q;
    commit_d = wr2_q;
    if (rst_s2_q) begin
      rd1_d = 1'b0;
      wr1_d = 1'b0;
      rd2_d = 1'b0;
      wr2_d = 1'b0;
      commit_d = 1'b0;
      ra1_d = '0;
      ra2_d = '0;
    end
  end

  always_ff @(posedge lnk.k) begin
    rd1_q <= rd1_d;
    rd2_q <= rd2_d;
    wr1_q <= wr1_d;
    wr2_q <= wr2_d;
    ra1_q <= ra1_d;
    ra2_q <= ra2_d;
    commit_q <= commit_d;
  end

  assign write_commit = commit_q;

  // First write beat and its masks are taken on the rising edge after the command.
  b2s_pkg::b2s_data_t wd0_d;
  b2s_pkg::b2s_data_t wd0_q;
  b2s_pkg::b2s_mask_t wm0_d;
  b2s_pkg::b2s_mask_t wm0_q;
  b2s_pkg::b2s_mask_t lane_mask_n;

  assign lane_mask_n = {lnk.byte_lane_mask3_n, lnk.byte_lane_mask2_n,
                        lnk.byte_lane_mask1_n, lnk.byte_lane_mask0_n};

  always_comb begin
    wd0_d = wd0_q;
    wm0_d = wm0_q;
    if (wr1_q) begin
      wd0_d = lnk.d;
      wm0_d = lane_mask_n;
    end
    if (rst_s2_q) begin
      wd0_d = '0;
      wm0_d = '1;
    end
  end

  always_ff @(posedge lnk.k) begin
    wd0_q <= wd0_d;
    wm0_q <= wm0_d;
  end

  // Second write beat is taken on the falling edge that follows.
  b2s_pkg::b2s_data_t wd1_d;
  b2s_pkg::b2s_data_t wd1_q;
  b2s_pkg::b2s_mask_t wm1_d;
  b2s_pkg::b2s_mask_t wm1_q;

  always_comb begin
    wd1_d = wd1_q;
    wm1_d = wm1_q;
    if (wr2_q) begin
      wd1_d = lnk.d;
      wm1_d = lane_mask_n;
    end
    if (rst_s2_q) begin
      wd1_d = '0;
      wm1_d = '1;
    end
  end

  always_ff @(negedge lnk.k) begin
    wd1_q <= wd1_d;
    wm1_q <= wm1_d;
  end

  // Burst addresses put bit 0 of a two-bit linear counter, started at B2S_BURST_START, below the base address.
  function automatic logic [IW-1:0] beat_index(input b2s_pkg::b2s_addr_t base, input logic [1:0] beat);
    logic [1:0] cnt;
    cnt = `B2S_BURST_START + beat;
    return {base[IW-2:0], cnt[0]};
  endfunction

  logic [IW-1:0] rix0;
  logic [IW-1:0] wix0;
  logic [IW-1:0] ix1;

  assign rix0 = beat_index(ra1_q, `B2S_BEAT0);
  assign wix0 = beat_index(ra2_q, `B2S_BEAT0);
  assign ix1 = beat_index(ra2_q, `B2S_BEAT1);

  // Each lane has its own storage so a cleared mask bit writes exactly that lane.
  b2s_pkg::b2s_data_t rb0;
  b2s_pkg::b2s_data_t rb1;

  for (genvar g = 0; g < `B2S_LANES; g++) begin : g_lane
    logic [LW-1:0] mem [DEPTH];

    always_ff @(posedge lnk.k) begin
      if (wr2_q && !rst_s2_q && !wm0_q[g]) begin
        mem[wix0] <= wd0_q[g*LW +: LW];
      end
      if (wr2_q && !rst_s2_q && !wm1_q[g]) begin
        mem[ix1] <= wd1_q[g*LW +: LW];
      end
    end

    assign rb0[g*LW +: LW] = mem[rix0];
    assign rb1[g*LW +: LW] = mem[ix1];
  end

  // Read data: beat 0 while stage 1 holds a read, beat 1 while stage 2 does.
  b2s_pkg::b2s_data_t q_d;
  logic oe_d;

  always_comb begin
    q_d = '0;
    oe_d = 1'b0;
    if (rd1_q) begin
      q_d = rb0;
      oe_d = 1'b1;
    end else if (rd2_q) begin
      q_d = rb1;
      oe_d = 1'b1;
    end
    if (rst_s2_q) begin
      q_d = '0;
      oe_d = 1'b0;
    end
  end

  // Normal timing registers on the rising edge; bypass registers half a cycle earlier on the fall.
  // With the link clock stopped both registers simply keep their last value.
  b2s_pkg::b2s_data_t qr_q;
  logic qr_oe_q;
  b2s_pkg::b2s_data_t qf_q;
  logic qf_oe_q;

  always_ff @(posedge lnk.k) begin
    qr_q <= q_d;
    qr_oe_q <= oe_d;
  end

  always_ff @(negedge lnk.k) begin
    qf_q <= q_d;
    qf_oe_q <= oe_d;
  end

  assign lnk.q = byp_q ? qf_q : qr_q;
  assign lnk.q_oe = byp_q ? qf_oe_q : qr_oe_q;

endmodule // b2s_sram_port

// [bench/b2s_monitor.sv]
`timescale 1ns/1ps
module b2s_monitor (
  input wire logic k,
  input wire logic link_rst,
  input wire logic lock_bypass_n,
  input wire logic new_address_select_n,
  input wire logic read_not_write,
  input wire logic q_oe
);
  wire rd_cmd = !new_address_select_n && read_not_write;
  wire wr_cmd = !new_address_select_n && !read_not_write;
  default clocking cb @(posedge k);
  endclocking
  default disable iff (link_rst);
  rd_beats_a: assert property (rd_cmd && lock_bypass_n |-> ##2 q_oe ##1 q_oe)
    else $error("read beats missing");
  rd_end_a: assert property (rd_cmd && lock_bypass_n ##1 1'b1 ##1 new_address_select_n |=> ##1 !q_oe)
    else $error("read burst too long");
  wr_quiet_a: assert property (wr_cmd && lock_bypass_n |-> ##2 !q_oe [*2])
    else $error("write drove outputs");
  nop_hiz_a: assert property (q_oe && lock_bypass_n |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
    else $error("outputs driven without read");
  byp_beats_a: assert property (rd_cmd && !lock_bypass_n |-> ##1 q_oe ##1 q_oe)
    else $error("bypass read beats missing");
  byp_src_a: assert property (q_oe && !lock_bypass_n |-> $past(rd_cmd) || $past(rd_cmd, 2))
    else $error("bypass outputs without read");
  cmd_gap_a: assert property (!new_address_select_n |=> new_address_select_n)
    else $error("commands too close");
  strap_hold_a: assert property ($stable(lock_bypass_n))
    else $error("bypass strap moved");
endmodule // b2s_monitor

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    b2s_pkg::b2s_addr_t addr;
    b2s_pkg::b2s_mask_t m0;
    b2s_pkg::b2s_mask_t m1;
    b2s_pkg::b2s_data_t e0;
    b2s_pkg::b2s_data_t e1;
  } b2s_row_t;
  localparam b2s_pkg::b2s_data_t all_ones = '1;
  logic mclk, rst, lock_bypass_req_n, req_valid, req_write, req_ready, rd_valid, bypass_active, write_commit;
  b2s_pkg::b2s_addr_t req_addr;
  b2s_pkg::b2s_data_t req_wdata0, req_wdata1, rd_data0, rd_data1, r0, r1;
  b2s_pkg::b2s_mask_t req_mask0_n, req_mask1_n;
  int errors, n_compared, n_commit, n_wr;
  b2s_row_t rows [7] = '{
    '{19'h00010, 4'he, 4'hd, 36'h0000001ff, 36'h00003fe00},
    '{19'h00011, 4'hd, 4'hb, 36'h00003fe00, 36'h007fc0000},
    '{19'h00012, 4'hb, 4'h7, 36'h007fc0000, 36'hff8000000},
    '{19'h00013, 4'h7, 4'h0, 36'hff8000000, 36'hfffffffff},
    '{19'h00014, 4'h0, 4'hf, 36'hfffffffff, 36'h000000000},
    '{19'h00015, 4'hf, 4'he, 36'h000000000, 36'h0000001ff},
    '{19'h00016, 4'hc, 4'h3, 36'h00003ffff, 36'hffffc0000}};
  b2s_if lnk_if();
  b2s_sram_port b2s_sram_port_i (.lnk(lnk_if.mem), .bypass_active(bypass_active), .write_commit(write_commit));
  b2s_bus_master b2s_bus_master_i (.lnk(lnk_if.ctl), .mclk(mclk), .rst(rst), .lock_bypass_req_n(lock_bypass_req_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata0(req_wdata0),
    .req_wdata1(req_wdata1), .req_mask0_n(req_mask0_n), .req_mask1_n(req_mask1_n), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1));
  b2s_monitor b2s_monitor_i (.k(lnk_if.k), .link_rst(lnk_if.link_rst), .lock_bypass_n(lnk_if.lock_bypass_n),
    .new_address_select_n(lnk_if.new_address_select_n), .read_not_write(lnk_if.read_not_write),
    .q_oe(lnk_if.q_oe));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge lnk_if.k) begin
    if (write_commit === 1'b1) n_commit++;
  end
  task automatic final_report;
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_d(input string nm, input b2s_pkg::b2s_data_t e, input b2s_pkg::b2s_data_t g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_b(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic do_reset(input logic byp);
    b2s_pkg::b2s_data_t held;
    @(negedge mclk);
    rst = 1'b1;
    lock_bypass_req_n = byp;
    @(negedge mclk);
    held = lnk_if.q;
    repeat (2) @(negedge mclk);
    // The link clock is stopped while the master sits in reset, so the read port must keep its value.
    if (n_compared > 0) cmp_d("q_held", held, lnk_if.q);
    rst = 1'b0;
  endtask
  task automatic req(input logic wr, input b2s_pkg::b2s_addr_t ad, input b2s_pkg::b2s_data_t w0,
    input b2s_pkg::b2s_data_t w1, input b2s_pkg::b2s_mask_t m0, input b2s_pkg::b2s_mask_t m1);
    int n;
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata0 = w0;
    req_wdata1 = w1;
    req_mask0_n = m0;
    req_mask1_n = m1;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    cmp_b("req_ready", 1'b1, req_ready);
    @(negedge mclk);
    req_valid = 1'b0;
    if (wr) n_wr++;
  endtask
  task automatic rd(input b2s_pkg::b2s_addr_t ad);
    int n;
    req(1'b0, ad, '0, '0, 4'hf, 4'hf);
    n = 0;
    while (rd_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    cmp_b("rd_valid", 1'b1, rd_valid);
    r0 = rd_data0;
    r1 = rd_data1;
  endtask
  initial begin
    #3000000;
    errors++;
    final_report();
  end
  initial begin
    {rst, req_valid, req_write, lock_bypass_req_n} = 4'h9;
    {req_addr, req_wdata0, req_wdata1} = '0;
    {req_mask0_n, req_mask1_n} = 8'hff;
    do_reset(1'b1);
    cmp_b("rd_valid", 1'b0, rd_valid);
    repeat (40) @(negedge mclk);
    cmp_b("q_oe", 1'b0, lnk_if.q_oe);
    cmp_b("bypass_active", 1'b0, bypass_active);
    foreach (rows[i]) begin
      req(1'b1, rows[i].addr, '0, '0, 4'h0, 4'h0);
      req(1'b1, rows[i].addr, all_ones, all_ones, rows[i].m0, rows[i].m1);
      rd(rows[i].addr);
      cmp_d("beat0", rows[i].e0, r0);
      cmp_d("beat1", rows[i].e1, r1);
    end
    cmp_d("commits", 36'(n_wr), 36'(n_commit));
    req(1'b1, 19'h001ff, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
    rd(19'h001ff);
    cmp_d("base", 36'h123456789, r0);
    cmp_d("next", 36'h9abcdef01, r1);
    do_reset(1'b0);
    req(1'b1, 19'h002aa, 36'h0f0f0f0f0, 36'h5a5a5a5a5, 4'h0, 4'h0);
    rd(19'h002aa);
    cmp_b("bypass_active", 1'b1, bypass_active);
    cmp_d("byp_beat0", 36'h0f0f0f0f0, r0);
    cmp_d("byp_beat1", 36'h5a5a5a5a5, r1);
    final_report();
  end
endmodule // tb_top
